/* hw/cal_core_engine.sv */
// Calibration sequencer for one DAC core
`timescale 1ns/1ps
module cal_core_engine (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic cal_tick,
   output logic      done
);
   import dac_cal_pkg::*;

   eng_regs_t st;
   eng_regs_t next_st;

   // Count calibration clock periods while enabled, then hold done
   always_comb begin
      next_st = st;
      case (st.state)
         ENG_IDLE: begin
            if (run) begin
               next_st.state = ENG_RUN;
               next_st.ticks = '0;
            end
         end
         ENG_RUN: begin
            // Completion wins over a stop in the same cycle; done clears a cycle later
            if (cal_tick && st.ticks == CAL_TICKS - 9'h001) begin
               next_st.state = ENG_DONE;
               next_st.done  = 1'b1;
            end else if (!run) begin
               next_st.state = ENG_IDLE;
            end else if (cal_tick) begin
               next_st.ticks = st.ticks + 9'h001;
            end
         end
         ENG_DONE: begin
            // Done holds until run drops: start bit, core select or clock enable cleared
            if (!run) begin
               next_st.state = ENG_IDLE;
               next_st.done  = 1'b0;
            end
         end
         default: begin
            next_st.state = ENG_IDLE;
            next_st.done  = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st.state <= ENG_IDLE;
         st.ticks <= '0;
         st.done  <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
endmodule // cal_core_engine

/* hw/dac_cal_control.sv */
// Self-calibration control and serial register port for a dual current-output DAC
`timescale 1ns/1ps
module dac_cal_control #(
   parameter int DATA_BITS = 14
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   input  wire dac_cal_pkg::spi_pins_t    spi_pins,
   input  wire logic [DATA_BITS-1:0]      i_code,
   input  wire logic [DATA_BITS-1:0]      q_code,
   output logic                           sdio_out,
   output logic                           sdio_oe,
   output logic [DATA_BITS-1:0]           i_positive_current_out,
   output logic [DATA_BITS-1:0]           i_negative_current_out,
   output logic [DATA_BITS-1:0]           q_positive_current_out,
   output logic [DATA_BITS-1:0]           q_negative_current_out
);
   import dac_cal_pkg::*;

   top_regs_t  st;
   top_regs_t  next_st;
   logic       i_core_cal_done;
   logic       q_core_cal_done;
   logic       run_i;
   logic       run_q;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       frame_idle;
   logic       bit_rise;
   logic       read_start;
   logic       write_commit;
   logic       read_bit_fall;
   logic       cal_clk_on;
   logic [2:0] div_code;
   logic       div_wrap;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   // Terminal count of the divider; codes past the top clamp to 2048
   function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] code);
      logic [2:0] c;
      c = (code > DIV_MAX_CODE) ? DIV_MAX_CODE : code;
      // One less than the factor, as the count starts at zero
      return DIV_W'((32'd1 << (DIV_BASE_LOG + 32'(c))) - 32'd1);
   endfunction

   // Register read mux; unmapped addresses read zero
   function automatic logic [7:0] read_reg(input logic [4:0] addr);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         CFG_ADDR:  v = st.cfg;
         // Status is read-only; writes to it are dropped
         STAT_ADDR: begin
            v[DONE_I_BIT] = i_core_cal_done;
            v[DONE_Q_BIT] = q_core_cal_done;
         end
         CTRL_ADDR: begin
            v[START_BIT]   = st.cal_start;
            v[UNCAL_I_BIT] = st.uncal[0];
            v[UNCAL_Q_BIT] = st.uncal[1];
         end
         default:   v = 8'h00;
      endcase
      return v;
   endfunction

   // Run condition of one core; shared by both engines
   function automatic logic core_runs(input logic start, input logic sel, input logic clk_on);
      return start & sel & clk_on;
   endfunction

   // Negative side of a channel: all-ones minus the code, widened to the carrier
   function automatic logic [CODE_W_MAX-1:0] complement_code(input logic [DATA_BITS-1:0] c);
      return CODE_W_MAX'(~c);
   endfunction

   // Edges seen only on the second synchroniser stage and its delayed copy
   assign sclk_rise = st.sclk_sync[1] & ~st.sclk_sync[2];
   assign sclk_fall = ~st.sclk_sync[1] & st.sclk_sync[2];
   assign wr_addr   = st.shift[11:7];
   assign wr_data   = {st.shift[6:0], st.sdio_sync[1]};

   // A process, not an assign, so status changes reach the mux even when
   // the address bits stand still
   always_comb begin
      rd_data = read_reg({st.shift[3:0], st.sdio_sync[1]});
   end

   // Frame position; rises past the sixteenth bit are ignored
   assign frame_idle    = st.cs_sync[1];
   assign bit_rise      = sclk_rise && st.count < FRAME_BITS;
   // The read flag is the first bit in: bit 6 after seven bits, bit 14 after fifteen
   assign read_start    = bit_rise && st.count == INSTR_LAST && st.shift[6];
   assign write_commit  = bit_rise && st.count == FRAME_LAST && !st.shift[14];
   assign read_bit_fall = sclk_fall && st.sdio_oe && st.count >= FIRST_RD_FALL
                          && st.count < FRAME_BITS;

   // Divider controls
   assign cal_clk_on = st.cfg[CLK_EN_BIT];
   assign div_code   = st.cfg[DIV_SEL_LSB +: 3];
   assign div_wrap   = st.div_cnt >= div_limit(div_code);

   // A core runs only when started, selected and its clock enabled
   assign run_i = core_runs(st.cal_start, st.cfg[SEL_I_BIT], cal_clk_on);
   assign run_q = core_runs(st.cal_start, st.cfg[SEL_Q_BIT], cal_clk_on);

   // Next-state logic for the serial port, registers, divider and data path
   always_comb begin
      next_st = st;
      // Synchronisers; the logic reads the second stage, and for the clock also the third
      next_st.sclk_sync = {st.sclk_sync[1], st.sclk_sync[0], spi_pins.sclk};
      next_st.cs_sync   = {st.cs_sync[0], spi_pins.cs_n};
      next_st.sdio_sync = {st.sdio_sync[0], spi_pins.sdio_in};

      // Serial frame: instruction byte with read flag in bit 7, then one data byte
      if (frame_idle) begin
         next_st.count   = '0;
         next_st.sdio_oe = 1'b0; // Release the line between frames
      end else if (bit_rise) begin
         // Shift in one bit, MSB first
         next_st.shift = {st.shift[14:0], st.sdio_sync[1]};
         next_st.count = st.count + 5'h01;
         // Read: the first data bit goes out right after the eighth rise
         if (read_start) begin
            next_st.sdio_out = rd_data[7];
            next_st.rd_shift = {rd_data[6:0], 1'b0};
            next_st.sdio_oe  = 1'b1;
         end
         // Write: the sixteenth rise completes the data byte and commits it
         if (write_commit) begin
            case (wr_addr)
               // Top two config bits have no function and read zero
               CFG_ADDR:  next_st.cfg = {2'b00, wr_data[5:0]};
               CTRL_ADDR: begin
                  // Only an all-zero write clears the flags
                  next_st.cal_start = wr_data[START_BIT];
                  if (wr_data == 8'h00) begin
                     next_st.uncal = 2'h0;
                  end
               end
               default:   next_st.cfg = st.cfg; // Writes elsewhere are dropped
            endcase
         end
      end else if (read_bit_fall) begin
         // Shift read data out on falling edges so the master samples on rising
         next_st.sdio_out = st.rd_shift[7];
         next_st.rd_shift = {st.rd_shift[6:0], 1'b0};
      end

      // Calibration clock divider, held in reset while disabled; the count
      // restarts on every enable, so the first tick comes one full period late
      next_st.cal_tick = 1'b0;
      if (!cal_clk_on) begin
         next_st.div_cnt = '0;
      end else if (div_wrap) begin
         next_st.div_cnt  = '0;
         next_st.cal_tick = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + DIV_W'(1);
      end

      // Straight-binary steering; negative side carries the complement
      next_st.i_pos = CODE_W_MAX'(i_code);
      next_st.i_neg = complement_code(i_code);
      next_st.q_pos = CODE_W_MAX'(q_code);
      next_st.q_neg = complement_code(q_code);
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st           <= '0;
         // Select synchroniser starts at its idle level so no frame opens at release
         st.cs_sync   <= 2'h3;
         st.cfg       <= CFG_RESET;
         st.cal_start <= START_RESET;
         st.uncal     <= UNCAL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Independent engines, one per core
   cal_core_engine u_i_engine (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (run_i),
      .cal_tick (st.cal_tick),
      .done     (i_core_cal_done)
   );

   // Q engine shares the tick, so both cores can run together
   cal_core_engine u_q_engine (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (run_q),
      .cal_tick (st.cal_tick),
      .done     (q_core_cal_done)
   );

   // Outputs come straight from the state register
   assign sdio_out               = st.sdio_out;
   assign sdio_oe                = st.sdio_oe;
   assign i_positive_current_out = st.i_pos[DATA_BITS-1:0];
   assign i_negative_current_out = st.i_neg[DATA_BITS-1:0];
   assign q_positive_current_out = st.q_pos[DATA_BITS-1:0];
   assign q_negative_current_out = st.q_neg[DATA_BITS-1:0];
endmodule // dac_cal_control

/* hw/dac_cal_pkg.sv */
// Shared constants, types and state records for the dual-core calibration control
package dac_cal_pkg;
   // Register addresses on the serial port
   localparam logic [4:0] CFG_ADDR      = 5'h0E;
   localparam logic [4:0] STAT_ADDR     = 5'h0F;
   localparam logic [4:0] CTRL_ADDR     = 5'h12;
   // Configuration register fields
   localparam int         DIV_SEL_LSB   = 0;
   localparam int         CLK_EN_BIT    = 3;
   localparam int         SEL_I_BIT     = 4;
   localparam int         SEL_Q_BIT     = 5;
   // Control and status register fields
   localparam int         START_BIT     = 4;
   localparam int         UNCAL_I_BIT   = 0;
   localparam int         UNCAL_Q_BIT   = 1;
   localparam int         DONE_I_BIT    = 6;
   localparam int         DONE_Q_BIT    = 7;
   // Values after reset
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam logic       START_RESET   = 1'b0;
   localparam logic [1:0] UNCAL_RESET   = 2'h3;
   // Divider: factor is 32 shifted left by the code, code 6 gives 2048
   localparam int         DIV_W         = 11;
   localparam int         DIV_BASE_LOG  = 5;
   localparam logic [2:0] DIV_MAX_CODE  = 3'h6;
   // Calibration length in calibration clock periods
   localparam logic [8:0] CAL_TICKS     = 9'h12C;
   // Serial frame: 8 instruction bits then 8 data bits
   localparam logic [4:0] INSTR_LAST    = 5'h07;
   localparam logic [4:0] FIRST_RD_FALL = 5'h09;
   localparam logic [4:0] FRAME_LAST    = 5'h0F;
   localparam logic [4:0] FRAME_BITS    = 5'h10;
   localparam int         CODE_W_MAX    = 14;

   typedef enum logic [2:0] {
      ENG_IDLE = 3'b001,
      ENG_RUN  = 3'b010,
      ENG_DONE = 3'b100
   } eng_state_t;

   typedef struct packed {
      eng_state_t state;
      logic [8:0] ticks;
      logic       done;
   } eng_regs_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdio_in;
   } spi_pins_t;

   typedef struct packed {
      logic [2:0]            sclk_sync;
      logic [1:0]            cs_sync;
      logic [1:0]            sdio_sync;
      logic [4:0]            count;
      logic [15:0]           shift;
      logic [7:0]            rd_shift;
      logic                  sdio_out;
      logic                  sdio_oe;
      logic [7:0]            cfg;
      logic                  cal_start;
      logic [1:0]            uncal;
      logic [DIV_W-1:0]      div_cnt;
      logic                  cal_tick;
      logic [CODE_W_MAX-1:0] i_pos;
      logic [CODE_W_MAX-1:0] i_neg;
      logic [CODE_W_MAX-1:0] q_pos;
      logic [CODE_W_MAX-1:0] q_neg;
   } top_regs_t;
endpackage

/* verif/dac_cal_chk.sv */
// Port-level assertions for the dual-core calibration control block
`timescale 1ns/1ps
module dac_cal_chk #(
   parameter int DATA_BITS = 14
) (
   input wire logic                    core_clk,
   input wire logic                    rst_n,
   input wire dac_cal_pkg::spi_pins_t  spi_pins,
   input wire logic [DATA_BITS-1:0]    i_code,
   input wire logic [DATA_BITS-1:0]    q_code,
   input wire logic                    sdio_out,
   input wire logic                    sdio_oe,
   input wire logic [DATA_BITS-1:0]    i_positive_current_out,
   input wire logic [DATA_BITS-1:0]    i_negative_current_out,
   input wire logic [DATA_BITS-1:0]    q_positive_current_out,
   input wire logic [DATA_BITS-1:0]    q_negative_current_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Current outputs follow the codes one clock late; skip the edge after reset
   property p_ip; $past(rst_n) |-> i_positive_current_out == $past(i_code); endproperty
   a_ip: assert property (p_ip) else $error("I positive output wrong");
   property p_in; $past(rst_n) |-> i_negative_current_out == ~$past(i_code); endproperty
   a_in: assert property (p_in) else $error("I negative output wrong");
   property p_qp; $past(rst_n) |-> q_positive_current_out == $past(q_code); endproperty
   a_qp: assert property (p_qp) else $error("Q positive output wrong");
   property p_qn; $past(rst_n) |-> q_negative_current_out == ~$past(q_code); endproperty
   a_qn: assert property (p_qn) else $error("Q negative output wrong");
   // Outputs still hold reset values at the first edge after release
   property p_rst;
      $rose(rst_n) |-> !sdio_oe && i_positive_current_out == '0 && q_negative_current_out == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not quiet after reset");
   // Read driver only inside a frame, and it holds while the frame lasts
   property p_oi; spi_pins.cs_n [*8] |-> !sdio_oe; endproperty
   a_oi: assert property (p_oi) else $error("data pin driven while deselected");
   property p_or; $rose(sdio_oe) |-> !spi_pins.cs_n; endproperty
   a_or: assert property (p_or) else $error("data pin driven without select");
   property p_oh; !spi_pins.cs_n [*4] ##0 sdio_oe |=> sdio_oe; endproperty
   a_oh: assert property (p_oh) else $error("data pin released inside frame");
   c_rd: cover property ($rose(sdio_oe));
   c_fs: cover property (i_positive_current_out == '1);
   c_zero: cover property ($past(rst_n) && q_positive_current_out == '0);
endmodule // dac_cal_chk

bind dac_cal_control dac_cal_chk #(.DATA_BITS(DATA_BITS)) chk_inst (
   .core_clk(core_clk), .rst_n(rst_n), .spi_pins(spi_pins), .i_code(i_code),
   .q_code(q_code), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
   .i_positive_current_out(i_positive_current_out),
   .i_negative_current_out(i_negative_current_out),
   .q_positive_current_out(q_positive_current_out),
   .q_negative_current_out(q_negative_current_out)
);

/* verif/dac_cal_control_bench.sv */
// Self-checking bench for the dual-core calibration control block
`timescale 1ns/1ps
module dac_cal_control_bench;
   import dac_cal_pkg::*;
   logic        core_clk;
   logic        rst_n;
   spi_pins_t   spi;
   logic [13:0] i_code, q_code, ip, in, qp, qn;
   logic        sdio_out, sdio_oe;
   logic [7:0]  rd;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          cyc = 0;

   dac_cal_control dac_cal_control_inst (
      .core_clk(core_clk), .rst_n(rst_n), .spi_pins(spi), .i_code(i_code),
      .q_code(q_code), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .i_positive_current_out(ip), .i_negative_current_out(in),
      .q_positive_current_out(qp), .q_negative_current_out(qn)
   );

   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
   endtask

   // One frame; sclk phases of 5 clocks leave room for the 2-FF synchronisers
   task automatic xfer(logic [7:0] ins, logic [7:0] wd);
      logic [15:0] v;
      v = {ins, wd};
      spi.cs_n <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         spi.sclk <= 1'b0;
         spi.sdio_in <= v[15-i];
         tick(5);
         spi.sclk <= 1'b1;
         tick(5);
         if (i > 7) rd[15-i] = sdio_out;
      end
      spi.sclk <= 1'b0;
      tick(5);
      spi.cs_n <= 1'b1;
      tick(8);
   endtask

   task automatic wr(logic [4:0] a, logic [7:0] d);
      xfer({3'h0, a}, d);
   endtask

   task automatic rchk(string n, logic [4:0] a, logic [7:0] e);
      xfer({3'h4, a}, 8'h00);
      chk(n, rd, e);
   endtask

   task automatic t_regs;
      rchk("cfg reset", CFG_ADDR, CFG_RESET);
      rchk("ctrl reset", CTRL_ADDR, 8'h03);
      rchk("status reset", STAT_ADDR, 8'h00);
      rchk("unmapped", 5'h05, 8'h00);
      wr(CFG_ADDR, 8'hFF);
      rchk("cfg rw", CFG_ADDR, 8'h3F);
      wr(STAT_ADDR, 8'hFF);
      rchk("status ro", STAT_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h10);
      rchk("ctrl start", CTRL_ADDR, 8'h13);
      wr(CTRL_ADDR, 8'h00);
      rchk("ctrl clear", CTRL_ADDR, 8'h00);
      wr(CFG_ADDR, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_data;
      logic [13:0] c [4] = '{14'h0000, 14'h0001, 14'h3FFF, 14'h1555};
      foreach (c[k]) begin
         i_code <= c[k];
         q_code <= 14'h3FFF - c[k];
         tick(2);
         chk("i pos", ip, c[k]);
         chk("i neg", in, 14'h3FFF - c[k]);
         chk("q pos", qp, 14'h3FFF - c[k]);
         chk("q neg", qn, c[k]);
      end
      $display("test data done");
   endtask

   // Reset in mid-run clears the start bit and sets both flags again
   task automatic t_reset;
      wr(CFG_ADDR, 8'h1B);
      wr(CTRL_ADDR, 8'h10);
      rst_n <= 1'b0;
      tick(5);
      rst_n <= 1'b1;
      tick(4);
      rchk("cfg after reset", CFG_ADDR, CFG_RESET);
      rchk("ctrl after reset", CTRL_ADDR, 8'h03);
      rchk("status after reset", STAT_ADDR, 8'h00);
      $display("test reset done");
   endtask

   // Done may come only between per*300-600 clocks after start and the status read 900 clocks and one frame later
   task automatic run_cal(logic [7:0] cfg, int per, logic [7:0] dn);
      wr(CFG_ADDR, cfg);
      wr(CTRL_ADDR, 8'h10);
      tick(per * 300 - 600);
      rchk("cal early", STAT_ADDR, 8'h00);
      tick(900);
      rchk("cal done", STAT_ADDR, dn);
      wr(CTRL_ADDR, 8'h00);
      rchk("done clear", STAT_ADDR, 8'h00);
      wr(CFG_ADDR, 8'h00);
      $display("test cal %h done", cfg);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Clock of 20 ns
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      spi = '{1'b0, 1'b1, 1'b0};
      i_code = '0;
      q_code = '0;
      tick(5);
      rst_n <= 1'b1;
      tick(4);
      t_regs;
      t_data;
      t_reset;
      // Divide by 32 and 64 give 1.56 and 0.78 MHz, inside the usable band
      run_cal(8'h18, 32, 8'h40);
      run_cal(8'h28, 32, 8'h80);
      run_cal(8'h31, 64, 8'h00);
      run_cal(8'h39, 64, 8'hC0);
      test_done;
   end

   // Hang guard, about a quarter above the expected run length
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 85000) begin
         n_mismatch++;
         test_done;
      end
   end
endmodule // dac_cal_control_bench
